// File: rtl/ctb_counter_timer.sv
`timescale 1ns/1ps
`default_nettype none

module ctb_edge_sync (
   input  wire logic mclk_i,
   input  wire logic rst_n_i,
   input  wire logic pin_i,
   output logic      level_o,
   output logic      fall_o
);
   logic [2:0] stage, next_stage;
   always_comb begin
      next_stage = {stage[1:0], pin_i};
   end
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         stage <= '0;
      end else begin
         stage <= next_stage;
      end
   end
   // First stage feeds only the second
   assign level_o = stage[1];
   assign fall_o  = stage[2] & ~stage[1];
endmodule
module ctb_counter_timer
   import ctb_pkg::*;
(
   input  wire logic       mclk_i,
   input  wire logic       rst_n_i,
   input  wire logic [7:0] sfr_addr_i,
   input  wire logic       sfr_wr_i,
   input  wire logic [7:0] sfr_wdata_i,
   input  wire logic       sfr_rd_i,
   output logic      [7:0] sfr_rdata_o,
   input  wire logic       ext_irq_zero_pin_i,
   input  wire logic       ext_irq_one_pin_i,
   input  wire logic       t0_ext_pin_i,
   input  wire logic       t1_ext_pin_i,
   input  wire logic       ext_clk_i,
   input  wire logic       low_freq_oscillator_i,
   input  wire logic       t3_irq_enable_i,
   output logic            t0_irq_o,
   output logic            t1_irq_o,
   output logic            t3_irq_o,
   output logic            t1_overflow_o
);
   logic [SYNC_N-1:0] pins, lvl, fall;
   logic [7:0]    tcon, clock_control_reg, tl0, th0, tl1, th1;
   logic [7:0]    next_tcon, next_clock_control_reg, next_tl0, next_th0, next_tl1, next_th1;
   ctb_timer_zero_one_mode_type  timer_zero_one_mode, next_timer_zero_one_mode;
   ctb_t3ctl_type t3ctl, next_t3ctl;
   logic [7:0]    t3l, t3h, t3rll, t3rlh;
   logic [7:0]    next_t3l, next_t3h, next_t3rll, next_t3rlh;
   logic [3:0]    pre_cnt, next_pre_cnt;
   logic [2:0]    ext_cnt, next_ext_cnt;
   logic [7:0]    rdata, next_rdata;
   logic          t1_ovf, next_t1_ovf;
   logic          set_h, set_l;
   assign pins = {ext_irq_one_pin_i, ext_irq_zero_pin_i,
                  low_freq_oscillator_i, ext_clk_i,
                  t1_ext_pin_i, t0_ext_pin_i};
   generate
      for (genvar g = 0; g < SYNC_N; g++) begin : g_sync
         ctb_edge_sync u_sync (
            .mclk_i  (mclk_i),
            .rst_n_i (rst_n_i),
            .pin_i   (pins[g]),
            .level_o (lvl[g]),
            .fall_o  (fall[g])
         );
      end
   endgenerate
   // One count step: {carry, high, low}
   function automatic logic [16:0] step(input logic [1:0] mode,
                                        input logic [7:0] hi,
                                        input logic [7:0] lo);
      logic [8:0]  low9;
      logic [13:0] cnt14;
      low9  = {1'b0, lo} + 9'h001;
      cnt14 = {1'b0, hi, lo[4:0]} + 14'h0001;
      case (mode)
         MODE_13BIT:  step = {cnt14[13], cnt14[12:5], lo[7:5], cnt14[4:0]};
         MODE_RELOAD: step = {low9[8], hi, low9[8] ? hi : low9[7:0]};
         MODE_SPLIT:  step = {low9[8], hi, low9[7:0]};
         default:     step = {1'b0, hi, lo} + 17'h00001;
      endcase
   endfunction
   logic        wr_tcon, wr_timer_zero_one_mode, wr_tl0, wr_th0, wr_tl1, wr_th1, wr_clock_control_reg;
   logic        wr_t3ctl, wr_t3rll, wr_t3rlh, wr_t3l, wr_t3h;
   assign wr_tcon  = sfr_wr_i && (sfr_addr_i == ADDR_TCON);
   assign wr_timer_zero_one_mode  = sfr_wr_i && (sfr_addr_i == ADDR_TIMER_ZERO_ONE_MODE);
   assign wr_tl0   = sfr_wr_i && (sfr_addr_i == ADDR_TL0);
   assign wr_th0   = sfr_wr_i && (sfr_addr_i == ADDR_TH0);
   assign wr_tl1   = sfr_wr_i && (sfr_addr_i == ADDR_TL1);
   assign wr_th1   = sfr_wr_i && (sfr_addr_i == ADDR_TH1);
   assign wr_clock_control_reg = sfr_wr_i && (sfr_addr_i == ADDR_CLOCK_CONTROL_REG);
   assign wr_t3ctl = sfr_wr_i && (sfr_addr_i == ADDR_T3CTL);
   assign wr_t3rll = sfr_wr_i && (sfr_addr_i == ADDR_T3RLL);
   assign wr_t3rlh = sfr_wr_i && (sfr_addr_i == ADDR_T3RLH);
   assign wr_t3l   = sfr_wr_i && (sfr_addr_i == ADDR_T3L);
   assign wr_t3h   = sfr_wr_i && (sfr_addr_i == ADDR_T3H);
   logic pre_tick, ext8_tick, split0;
   logic irq0_act, irq1_act, t0_run, t1_run, t0h_run;
   logic t0_tick, t1_tick, t0_clk, t1_clk;
   logic [16:0] r0, r1;
   logic [8:0]  th0_sum;
   assign pre_tick  = (pre_cnt == PRESCALE_LAST);
   assign ext8_tick = fall[SYNC_EXT] && (ext_cnt == EXT_DIV_LAST);
   assign split0    = (timer_zero_one_mode.t0.mode == MODE_SPLIT);
   assign irq0_act  = (lvl[SYNC_IRQ0] == tcon[POL0_BIT]);
   assign irq1_act  = (lvl[SYNC_IRQ1] == tcon[POL1_BIT]);
   assign t0_clk    = clock_control_reg[T0CK_BIT] | pre_tick;
   assign t1_clk    = clock_control_reg[T1CK_BIT] | pre_tick;
   assign t0_tick = timer_zero_one_mode.t0.counter_select ? fall[SYNC_T0] : t0_clk;
   assign t0_run  = tcon[TR0_BIT] && (!timer_zero_one_mode.t0.gate || irq0_act)
                    && t0_tick;
   // External pin ignored while timer zero is split
   assign t1_tick = (timer_zero_one_mode.t1.counter_select && !split0) ?
                    fall[SYNC_T1] : t1_clk;
   // Split: run follows the mode field alone
   assign t1_run  = (timer_zero_one_mode.t1.mode != MODE_SPLIT) && t1_tick &&
                    (split0 || (tcon[TR1_BIT] &&
                                (!timer_zero_one_mode.t1.gate || irq1_act)));
   assign t0h_run = split0 && tcon[TR1_BIT] && t0_clk;
   assign r0      = step(timer_zero_one_mode.t0.mode, th0, tl0);
   assign r1      = step(timer_zero_one_mode.t1.mode, th1, tl1);
   assign th0_sum = {1'b0, th0} + 9'h001;
   always_comb begin
      next_tcon    = tcon;
      next_timer_zero_one_mode    = timer_zero_one_mode;
      next_clock_control_reg   = clock_control_reg;
      next_tl0     = tl0;
      next_th0     = th0;
      next_tl1     = tl1;
      next_th1     = th1;
      next_pre_cnt = pre_tick ? '0 : pre_cnt + 4'h1;
      next_ext_cnt = fall[SYNC_EXT] ? ext_cnt + 3'h1 : ext_cnt;
      next_t1_ovf  = t1_run && r1[16];
      if (t0_run) begin
         next_th0 = r0[15:8];
         next_tl0 = r0[7:0];
      end
      if (t0h_run) begin
         next_th0 = th0_sum[7:0];
      end
      if (t1_run) begin
         next_th1 = r1[15:8];
         next_tl1 = r1[7:0];
      end
      if (wr_tcon) next_tcon = sfr_wdata_i & TCON_MASK;
      if (wr_timer_zero_one_mode) next_timer_zero_one_mode = ctb_timer_zero_one_mode_type'(sfr_wdata_i);
      if (wr_clock_control_reg) next_clock_control_reg = sfr_wdata_i & CLOCK_CONTROL_REG_MASK;
      if (wr_tl0) next_tl0 = sfr_wdata_i;
      if (wr_th0) next_th0 = sfr_wdata_i;
      if (wr_tl1) next_tl1 = sfr_wdata_i;
      if (wr_th1) next_th1 = sfr_wdata_i;
      // Hardware set beats a software clear
      if (t0_run && r0[16]) next_tcon[TF0_BIT] = 1'b1;
      if (split0 ? (t0h_run && th0_sum[8]) : (t1_run && r1[16])) begin
         next_tcon[TF1_BIT] = 1'b1;
      end
   end
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         tcon    <= REG_RESET;
         timer_zero_one_mode    <= ctb_timer_zero_one_mode_type'(REG_RESET);
         clock_control_reg   <= REG_RESET;
         tl0     <= REG_RESET;
         th0     <= REG_RESET;
         tl1     <= REG_RESET;
         th1     <= REG_RESET;
         pre_cnt <= '0;
         ext_cnt <= '0;
         t1_ovf  <= 1'b0;
      end else begin
         tcon    <= next_tcon;
         timer_zero_one_mode    <= next_timer_zero_one_mode;
         clock_control_reg   <= next_clock_control_reg;
         tl0     <= next_tl0;
         th0     <= next_th0;
         tl1     <= next_tl1;
         th1     <= next_th1;
         pre_cnt <= next_pre_cnt;
         ext_cnt <= next_ext_cnt;
         t1_ovf  <= next_t1_ovf;
      end
   end
   logic        t3_lo_tick, t3_hi_tick, capture;
   logic [8:0]  lo3_sum, hi3_sum;
   logic [16:0] w3_sum;
   assign t3_lo_tick = clock_control_reg[T3_LOW_CLOCK_SELECT_BIT] ? 1'b1 :
                       (t3ctl.ext_clk ? ext8_tick : pre_tick);
   assign t3_hi_tick = clock_control_reg[T3_HIGH_CLOCK_SELECT_BIT] ? 1'b1 :
                       (t3ctl.ext_clk ? ext8_tick : pre_tick);
   assign capture = fall[SYNC_LFO] && t3ctl.capture_en && !t3ctl.split;
   assign lo3_sum = {1'b0, t3l} + 9'h001;
   assign hi3_sum = {1'b0, t3h} + 9'h001;
   assign w3_sum  = {1'b0, t3h, t3l} + 17'h00001;
   always_comb begin
      next_t3ctl = t3ctl;
      next_t3l   = t3l;
      next_t3h   = t3h;
      next_t3rll = t3rll;
      next_t3rlh = t3rlh;
      set_h      = 1'b0;
      set_l      = 1'b0;
      if (t3ctl.capture_en && !t3ctl.split) begin
         // Free 16-bit wrap, no reload
         if (t3ctl.run && t3_lo_tick) begin
            {next_t3h, next_t3l} = w3_sum[15:0];
            set_h = w3_sum[16];
         end
      end else if (t3ctl.split) begin
         // Low half ignores run
         if (t3_lo_tick) begin
            next_t3l = lo3_sum[8] ? t3rll : lo3_sum[7:0];
            set_l    = lo3_sum[8];
         end
         if (t3ctl.run && t3_hi_tick) begin
            next_t3h = hi3_sum[8] ? t3rlh : hi3_sum[7:0];
            set_h    = hi3_sum[8];
         end
      end else if (t3ctl.run && t3_lo_tick) begin
         {next_t3h, next_t3l} = w3_sum[16] ? {t3rlh, t3rll} : w3_sum[15:0];
         set_h = w3_sum[16];
      end
      if (wr_t3ctl) next_t3ctl = ctb_t3ctl_type'(sfr_wdata_i);
      if (wr_t3l) next_t3l = sfr_wdata_i;
      if (wr_t3h) next_t3h = sfr_wdata_i;
      if (wr_t3rll) next_t3rll = sfr_wdata_i;
      if (wr_t3rlh) next_t3rlh = sfr_wdata_i;
      // Capture beats a same-cycle reload write
      if (capture) begin
         next_t3rlh = t3h;
         next_t3rll = t3l;
         set_l      = 1'b1;
      end
      // Hardware sets the flags here; a software write above can also set them
      if (set_h) next_t3ctl.high_flag = 1'b1;
      if (set_l) next_t3ctl.low_flag = 1'b1;
      if (next_t3ctl.capture_en) next_t3ctl.capture_src = 1'b1;
   end
   always_comb begin
      case (sfr_addr_i)
         ADDR_TCON:  next_rdata = tcon;
         ADDR_TIMER_ZERO_ONE_MODE:  next_rdata = timer_zero_one_mode;
         ADDR_TL0:   next_rdata = tl0;
         ADDR_TH0:   next_rdata = th0;
         ADDR_TL1:   next_rdata = tl1;
         ADDR_TH1:   next_rdata = th1;
         ADDR_CLOCK_CONTROL_REG: next_rdata = clock_control_reg;
         ADDR_T3CTL: next_rdata = t3ctl;
         ADDR_T3RLL: next_rdata = t3rll;
         ADDR_T3RLH: next_rdata = t3rlh;
         ADDR_T3L:   next_rdata = t3l;
         ADDR_T3H:   next_rdata = t3h;
         default:    next_rdata = REG_RESET;
      endcase
      if (!sfr_rd_i) next_rdata = rdata;
   end
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         t3ctl <= ctb_t3ctl_type'(REG_RESET);
         t3l   <= REG_RESET;
         t3h   <= REG_RESET;
         t3rll <= REG_RESET;
         t3rlh <= REG_RESET;
         rdata <= REG_RESET;
      end else begin
         t3ctl <= next_t3ctl;
         t3l   <= next_t3l;
         t3h   <= next_t3h;
         t3rll <= next_t3rll;
         t3rlh <= next_t3rlh;
         rdata <= next_rdata;
      end
   end
   assign sfr_rdata_o   = rdata;
   assign t1_overflow_o = t1_ovf;
   assign t0_irq_o      = tcon[TF0_BIT];
   assign t1_irq_o      = tcon[TF1_BIT];
   // Capture requests regardless of low enable
   assign t3_irq_o = t3_irq_enable_i && (t3ctl.high_flag ||
                     ((t3ctl.low_irq_en || t3ctl.capture_en)
                      && t3ctl.low_flag));
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!rst_n_i);
   sequence s_t3h_roll;
      t3ctl.split && t3ctl.run && t3_hi_tick && t3h == 8'hff
      && !wr_t3ctl && !wr_t3h;
   endsequence
   sequence s_lfo_capture;
      capture && !wr_t3ctl;
   endsequence
   a_split_high_hold: assert property (split0 && !tcon[TR1_BIT] && !wr_th0
      |=> th0 == $past(th0)) else $error("high byte moved");
   a_split_sets_tf1: assert property (t0h_run && th0 == 8'hff && !wr_tcon
      |=> tcon[TF1_BIT]) else $error("split overflow lost");
   a_t1_no_flag: assert property (split0 && !t0h_run && !wr_tcon
      && !tcon[TF1_BIT] |=> !tcon[TF1_BIT]) else $error("tf1 set");
   a_t1_mode3_stop: assert property (split0 && timer_zero_one_mode.t1.mode == MODE_SPLIT
      && !wr_tl1 && !wr_th1 |=> $stable(tl1) && $stable(th1))
      else $error("timer one ran in mode 3");
   a_gate_blocks: assert property (timer_zero_one_mode.t0.gate && !irq0_act && !wr_tl0
      |=> $stable(tl0)) else $error("gated timer counted");
   a_t3_low_free: assert property (t3ctl.split && clock_control_reg[T3_LOW_CLOCK_SELECT_BIT]
      && t3l != 8'hff && !wr_t3l |=> t3l == $past(t3l) + 8'h01)
      else $error("low half not free running");
   a_t3_div12: assert property (t3ctl.split && !clock_control_reg[T3_LOW_CLOCK_SELECT_BIT]
      && !t3ctl.ext_clk && !pre_tick && !wr_t3l |=> $stable(t3l))
      else $error("low half off prescale");
   a_t3h_flag: assert property (s_t3h_roll |=> t3ctl.high_flag
      && t3h == $past(t3rlh)) else $error("high roll");
   a_t3_irq: assert property (t3ctl.high_flag && t3_irq_enable_i
      |-> t3_irq_o) else $error("no timer three request");
   a_capture_copy: assert property (s_lfo_capture |=> t3ctl.low_flag
      && {t3rlh, t3rll} == $past({t3h, t3l})) else $error("capture");
endmodule
`default_nettype wire

// File: rtl/ctb_pkg.sv
package ctb_pkg;
   // Special function register addresses
   localparam logic [7:0] ADDR_TCON     = 8'h88;
   localparam logic [7:0] ADDR_TIMER_ZERO_ONE_MODE     = 8'h89;
   localparam logic [7:0] ADDR_TL0      = 8'h8a;
   localparam logic [7:0] ADDR_TL1      = 8'h8b;
   localparam logic [7:0] ADDR_TH0      = 8'h8c;
   localparam logic [7:0] ADDR_TH1      = 8'h8d;
   localparam logic [7:0] ADDR_CLOCK_CONTROL_REG    = 8'h8e;
   localparam logic [7:0] ADDR_T3CTL    = 8'h91;
   localparam logic [7:0] ADDR_T3RLL    = 8'h92;
   localparam logic [7:0] ADDR_T3RLH    = 8'h93;
   localparam logic [7:0] ADDR_T3L      = 8'h94;
   localparam logic [7:0] ADDR_T3H      = 8'h95;

   localparam logic [7:0] REG_RESET     = 8'h00;
   localparam logic [7:0] TCON_MASK     = 8'hf3;
   localparam logic [7:0] CLOCK_CONTROL_REG_MASK    = 8'hcc;

   // Timer run/flag and irq pin polarity bit positions
   localparam int TF1_BIT  = 7;
   localparam int TR1_BIT  = 6;
   localparam int TF0_BIT  = 5;
   localparam int TR0_BIT  = 4;
   localparam int POL1_BIT = 1;
   localparam int POL0_BIT = 0;
   // Clock control bit positions
   localparam int T3_HIGH_CLOCK_SELECT_BIT = 7;
   localparam int T3_LOW_CLOCK_SELECT_BIT = 6;
   localparam int T1CK_BIT = 3;
   localparam int T0CK_BIT = 2;

   // Timing: system clock / 12 and external clock / 8
   localparam logic [3:0] PRESCALE_LAST = 4'hb;
   localparam logic [2:0] EXT_DIV_LAST  = 3'h7;

   localparam logic [1:0] MODE_13BIT  = 2'h0;
   localparam logic [1:0] MODE_16BIT  = 2'h1;
   localparam logic [1:0] MODE_RELOAD = 2'h2;
   localparam logic [1:0] MODE_SPLIT  = 2'h3;

   localparam int SYNC_T0   = 0;
   localparam int SYNC_T1   = 1;
   localparam int SYNC_EXT  = 2;
   localparam int SYNC_LFO  = 3;
   localparam int SYNC_IRQ0 = 4;
   localparam int SYNC_IRQ1 = 5;
   localparam int SYNC_N    = 6;

   typedef struct packed {
      logic       gate;
      logic       counter_select;
      logic [1:0] mode;
   } ctb_tmode_type;

   typedef struct packed {
      ctb_tmode_type t1;
      ctb_tmode_type t0;
   } ctb_timer_zero_one_mode_type;

   typedef struct packed {
      logic high_flag;
      logic low_flag;
      logic low_irq_en;
      logic capture_en;
      logic split;
      logic run;
      logic capture_src;
      logic ext_clk;
   } ctb_t3ctl_type;
endpackage

// File: bench/ctb_pin_model.sv
`timescale 1ns/1ps
`default_nettype none

module ctb_pin_model
   import ctb_pkg::*;
(
   input  wire logic              mclk_i,
   output logic      [SYNC_N-1:0] pins_o
);
   initial pins_o = '0;

   // Levels held three cycles, beyond the two-cycle minimum
   task automatic pulse(input int idx, input int n);
      for (int i = 0; i < n; i++) begin
         repeat (3) @(posedge mclk_i);
         pins_o[idx] <= 1'b1;
         repeat (3) @(posedge mclk_i);
         pins_o[idx] <= 1'b0;
      end
      repeat (4) @(posedge mclk_i);
   endtask

   task automatic level(input int idx, input logic v);
      @(posedge mclk_i);
      pins_o[idx] <= v;
   endtask
endmodule

`default_nettype wire

// File: bench/tb_counter_timer_block.sv
`timescale 1ns/1ps
`default_nettype none

module tb_counter_timer_block
   import ctb_pkg::*;
;
   logic              mclk_i = 1'b0;
   logic              rst_n_i = 1'b0;
   logic        [7:0] sfr_addr_i = 8'h00;
   logic              sfr_wr_i = 1'b0;
   logic        [7:0] sfr_wdata_i = 8'h00;
   logic              sfr_rd_i = 1'b0;
   logic        [7:0] sfr_rdata_o;
   logic              t3_irq_enable_i = 1'b0;
   logic              t0_irq_o;
   logic              t1_irq_o;
   logic              t3_irq_o;
   logic              t1_overflow_o;
   logic [SYNC_N-1:0] pins;
   logic        [2:0] irqs;
   logic        [7:0] v;
   logic        [7:0] w;
   logic        [7:0] u;
   int                error_cnt = 0;
   int                checks_done = 0;
   int                ovf_cnt = 0;
   int                ovf0;
   logic        [7:0] addrs [12] = '{ADDR_TCON, ADDR_TIMER_ZERO_ONE_MODE, ADDR_TL0,
      ADDR_TL1, ADDR_TH0, ADDR_TH1, ADDR_CLOCK_CONTROL_REG, ADDR_T3CTL, ADDR_T3RLL,
      ADDR_T3RLH, ADDR_T3L, ADDR_T3H};

   assign irqs = {t3_irq_o, t1_irq_o, t0_irq_o};

   always #5 mclk_i = ~mclk_i;

   always @(posedge mclk_i) begin
      if (t1_overflow_o === 1'b1) begin
         ovf_cnt <= ovf_cnt + 1;
      end
   end

   ctb_pin_model pm (
      .mclk_i (mclk_i),
      .pins_o (pins)
   );

   ctb_counter_timer uut (
      .mclk_i                (mclk_i),
      .rst_n_i               (rst_n_i),
      .sfr_addr_i            (sfr_addr_i),
      .sfr_wr_i              (sfr_wr_i),
      .sfr_wdata_i           (sfr_wdata_i),
      .sfr_rd_i              (sfr_rd_i),
      .sfr_rdata_o           (sfr_rdata_o),
      .ext_irq_zero_pin_i    (pins[SYNC_IRQ0]),
      .ext_irq_one_pin_i     (pins[SYNC_IRQ1]),
      .t0_ext_pin_i          (pins[SYNC_T0]),
      .t1_ext_pin_i          (pins[SYNC_T1]),
      .ext_clk_i             (pins[SYNC_EXT]),
      .low_freq_oscillator_i (pins[SYNC_LFO]),
      .t3_irq_enable_i       (t3_irq_enable_i),
      .t0_irq_o              (t0_irq_o),
      .t1_irq_o              (t1_irq_o),
      .t3_irq_o              (t3_irq_o),
      .t1_overflow_o         (t1_overflow_o)
   );

   task automatic test_done();
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [7:0] seen,
                      input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk_i);
      sfr_addr_i <= a;
      sfr_wdata_i <= d;
      sfr_wr_i <= 1'b1;
      @(posedge mclk_i);
      sfr_wr_i <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge mclk_i);
      sfr_addr_i <= a;
      sfr_rd_i <= 1'b1;
      @(posedge mclk_i);
      sfr_rd_i <= 1'b0;
      #1 d = sfr_rdata_o;
   endtask

   task automatic rchk(input logic [7:0] a, input logic [7:0] exp,
                       input string what);
      logic [7:0] d;
      rd(a, d);
      chk(what, d, exp);
   endtask

   task automatic wait_irq(input int k, input int lim);
      int n;
      n = 0;
      while (irqs[k] !== 1'b1 && n < lim) begin
         @(posedge mclk_i);
         n++;
      end
      if (irqs[k] !== 1'b1) begin
         chk("irq wait", 8'h00, 8'h01);
         test_done();
      end
   endtask

   initial begin
      repeat (6) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      foreach (addrs[i]) rchk(addrs[i], REG_RESET, "reset value");
      wr(8'h90, 8'hff);
      rchk(8'h90, 8'h00, "unmapped");
      wr(ADDR_TCON, 8'h0f);
      rchk(ADDR_TCON, 8'h03, "tcon bits");
      wr(ADDR_CLOCK_CONTROL_REG, 8'h33);
      rchk(ADDR_CLOCK_CONTROL_REG, 8'h00, "clock_control_reg bits");
      wr(ADDR_TIMER_ZERO_ONE_MODE, 8'ha5);
      rchk(ADDR_TIMER_ZERO_ONE_MODE, 8'ha5, "mode rw");
      // Timer zero counting pin falls, then gated by irq pin
      wr(ADDR_TIMER_ZERO_ONE_MODE, 8'h05);
      wr(ADDR_TCON, 8'h11);
      pm.pulse(SYNC_T0, 5);
      rchk(ADDR_TL0, 8'h05, "pin count");
      wr(ADDR_TIMER_ZERO_ONE_MODE, 8'h0d);
      pm.pulse(SYNC_T0, 3);
      rchk(ADDR_TL0, 8'h05, "gate closed");
      pm.level(SYNC_IRQ0, 1'b1);
      pm.pulse(SYNC_T0, 2);
      rchk(ADDR_TL0, 8'h07, "gate open");
      wr(ADDR_TIMER_ZERO_ONE_MODE, 8'h06);
      wr(ADDR_TH0, 8'h40);
      wr(ADDR_TL0, 8'hfe);
      pm.pulse(SYNC_T0, 3);
      rchk(ADDR_TL0, 8'h41, "reload");
      chk("t0 flag", {7'h0, t0_irq_o}, 8'h01);
      wr(ADDR_TIMER_ZERO_ONE_MODE, 8'h04);
      wr(ADDR_TH0, 8'h00);
      wr(ADDR_TL0, 8'h1f);
      pm.pulse(SYNC_T0, 1);
      rchk(ADDR_TH0, 8'h01, "13-bit carry");
      wr(ADDR_TIMER_ZERO_ONE_MODE, 8'h05);
      wr(ADDR_TL0, 8'h1f);
      pm.pulse(SYNC_T0, 1);
      rchk(ADDR_TL0, 8'h20, "16-bit low");
      // Split timer zero; timer one free-running beside it
      wr(ADDR_TCON, 8'h10);
      wr(ADDR_CLOCK_CONTROL_REG, 8'h0c);
      wr(ADDR_TH1, 8'hf0);
      wr(ADDR_TL1, 8'hf0);
      wr(ADDR_TIMER_ZERO_ONE_MODE, 8'h67);
      wr(ADDR_TL0, 8'h00);
      wr(ADDR_TH0, 8'hfe);
      ovf0 = ovf_cnt;
      pm.pulse(SYNC_T0, 2);
      rchk(ADDR_TL0, 8'h02, "split low");
      rchk(ADDR_TH0, 8'hfe, "split high idle");
      chk("t1 ticks", {7'h0, ovf_cnt > ovf0}, 8'h01);
      chk("t1 no flag", {7'h0, t1_irq_o}, 8'h00);
      wr(ADDR_TIMER_ZERO_ONE_MODE, 8'h37);
      repeat (2) @(posedge mclk_i);
      ovf0 = ovf_cnt;
      repeat (40) @(posedge mclk_i);
      chk("t1 stopped", {7'h0, ovf_cnt == ovf0}, 8'h01);
      wr(ADDR_TCON, 8'h50);
      wait_irq(1, 10);
      rchk(ADDR_TL0, 8'h02, "split low kept");
      wr(ADDR_TCON, 8'h00);
      // Timer three halves from external clock, then from /12
      wr(ADDR_CLOCK_CONTROL_REG, 8'h00);
      wr(ADDR_T3CTL, 8'h0d);
      pm.pulse(SYNC_EXT, 16);
      rchk(ADDR_T3H, 8'h02, "t3 ext div");
      rchk(ADDR_T3L, 8'h02, "t3 low ext");
      wr(ADDR_T3CTL, 8'h0c);
      repeat (240) @(posedge mclk_i);
      wr(ADDR_T3CTL, 8'h08);
      rd(ADDR_T3H, v);
      chk("t3 div12", {7'h0, v >= 8'd21 && v <= 8'd23}, 8'h01);
      rd(ADDR_T3L, w);
      repeat (36) @(posedge mclk_i);
      rchk(ADDR_T3H, v, "t3 high held");
      rd(ADDR_T3L, u);
      chk("t3 low runs", {7'h0, u != w}, 8'h01);
      t3_irq_enable_i <= 1'b1;
      wr(ADDR_CLOCK_CONTROL_REG, 8'h40);
      wr(ADDR_T3RLL, 8'hf0);
      wr(ADDR_T3L, 8'hf0);
      repeat (40) @(posedge mclk_i);
      rd(ADDR_T3CTL, v);
      chk("low flag", v & 8'hc0, 8'h40);
      chk("low irq masked", {7'h0, t3_irq_o}, 8'h00);
      rd(ADDR_T3L, v);
      chk("low reload", v & 8'hf0, 8'hf0);
      wr(ADDR_T3CTL, 8'h68);
      wait_irq(2, 4);
      // Flags stay until software writes them clear
      wr(ADDR_T3CTL, 8'h08);
      #1;
      chk("irq cleared", {7'h0, t3_irq_o}, 8'h00);
      wr(ADDR_T3H, 8'hff);
      wr(ADDR_CLOCK_CONTROL_REG, 8'hc0);
      wr(ADDR_T3CTL, 8'h0c);
      wait_irq(2, 10);
      // Capture on oscillator falls, spaced 14 cycles by the model and the two reads between
      wr(ADDR_T3CTL, 8'h00);
      wr(ADDR_T3CTL, 8'h14);
      rd(ADDR_T3CTL, v);
      chk("capture src", v & 8'h1e, 8'h16);
      pm.pulse(SYNC_LFO, 1);
      rd(ADDR_T3RLL, w);
      rd(ADDR_T3RLH, u);
      pm.pulse(SYNC_LFO, 1);
      rd(ADDR_T3RLL, v);
      chk("capture span", v - w, 8'h0e);
      rd(ADDR_T3CTL, v);
      chk("capture flag", v & 8'h40, 8'h40);
      chk("capture irq", {7'h0, t3_irq_o}, 8'h01);
      test_done();
   end
endmodule

`default_nettype wire
